// ===== rtl/sdcr_if.sv
// Interface between the register block and its seed loader.
// Assumes both ends share the block clock and synchronised reset.
`default_nettype none

interface sdcr_if
    import sdcr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n
);
    sdcr_seed_code_t    seed_code;     // Stored seed selection.
    logic               load_en;       // Seed transfer enable.
    logic               freq_change;   // Frequency change strobe.
    logic [SEED_W-1:0]  seed_value;    // Seed handed to the modulator.
    logic               seed_load;     // One-cycle load pulse.

    modport cfg (
        input  clk,
        input  rst_n,
        output seed_code,
        output load_en,
        output freq_change,
        input  seed_value,
        input  seed_load
    );

    modport ldr (
        input  clk,
        input  rst_n,
        input  seed_code,
        input  load_en,
        input  freq_change,
        output seed_value,
        output seed_load
    );
endinterface

`default_nettype wire

// ===== rtl/sdcr_pkg.sv
// Constants for the modulator configuration register block.
// Assumes one 100 MHz clock and a register port fed by the serial engine.
//
// Notes on behaviour
// (RULE1) Reset value 0x200B4A at offset 0x06.
// (RULE2) Seed code picks zero, LSB, or fixed seeds.
// (RULE3) Seed stored; loaded on frequency change if bit8.
// (RULE4) Bypass ignores modulator; clock follows core enable.
// (RULE5) Software clears bypass fractional, sets it integer.
// (RULE6) Core enable picks which write starts autocalibration.
// (RULE7) Core enable zero disables core, one runs it.
// (RULE8) Software writes init 7 and clock config 0.
`default_nettype none

package sdcr_pkg;

    // ****************************************************************
    // Register map and field layout.
    // ****************************************************************
    localparam int          ADDR_W          = 6;
    localparam int          DATA_W          = 24;
    localparam int          CFG_W           = 23;
    localparam int          SEED_W          = 24;
    localparam logic [5:0]  CFG_OFFSET      = 6'h06;
    localparam logic [22:0] CFG_RESET       = 23'h200B4A;
    localparam int          SEED_LSB        = 0;
    localparam int          SEED_MSB        = 1;
    localparam int          BYPASS_BIT      = 7;
    localparam int          INIT_LSB        = 8;
    localparam int          INIT_MSB        = 10;
    localparam int          LOAD_EN_BIT     = 8;
    localparam int          CORE_ON_BIT     = 11;
    localparam int          AUTO_CLK_BIT    = 21;

    // ****************************************************************
    // Seed codes and the values they select.
    // ****************************************************************
    typedef logic [1:0] sdcr_seed_code_t;
    localparam logic [23:0] SEED_ZERO       = 24'h000000;
    localparam logic [23:0] SEED_LSB_VAL    = 24'h000001;
    localparam logic [23:0] SEED_FIX_A      = 24'hB29D08;
    localparam logic [23:0] SEED_FIX_B      = 24'h50F1CD;
    // The active seed starts as the default code selects.
    localparam logic [23:0] SEED_RESET      = 24'hB29D08;

endpackage

`default_nettype wire

// ===== rtl/sdcr_seed_loader.sv
// Seed loader: turns the stored seed code into the modulator seed.
// Assumes the frequency change strobe is a one-cycle pulse.
`default_nettype none

module sdcr_seed_loader
    import sdcr_pkg::*;
(
    sdcr_if.ldr bus
);

    // ****************************************************************
    // Seed lookup.
    // ****************************************************************
    // Maps a seed code onto its starting value.
    function automatic logic [SEED_W-1:0] seed_of(sdcr_seed_code_t c);
        logic [SEED_W-1:0] v;
        v = SEED_ZERO;
        unique case (c)
            2'h0: v = SEED_ZERO;
            2'h1: v = SEED_LSB_VAL;
            2'h2: v = SEED_FIX_A;
            2'h3: v = SEED_FIX_B;
        endcase
        return v;
    endfunction

    logic [SEED_W-1:0] seed_reg;      // Seed held by the modulator.
    logic [SEED_W-1:0] seed_next;     // Next held seed.
    logic              load_reg;      // Load pulse register.
    wire logic         do_load;       // Transfer condition.

    // The seed moves only on a change with the enable set.
    assign do_load   = bus.freq_change && bus.load_en; // RULE3
    assign seed_next = do_load ? seed_of(bus.seed_code) : seed_reg; // RULE2

    // Holding stage; stays put between frequency changes.
    always_ff @(posedge bus.clk or negedge bus.rst_n)
    begin
        if (!bus.rst_n)
        begin
            seed_reg <= SEED_RESET;
            load_reg <= 1'b0;
        end
        else
        begin
            seed_reg <= seed_next;
            load_reg <= do_load;
        end
    end

    assign bus.seed_value = seed_reg;
    assign bus.seed_load  = load_reg;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    property p_seed_load;
        @(posedge bus.clk) disable iff (!bus.rst_n)
        (bus.freq_change && bus.load_en) |=>
            (bus.seed_load && bus.seed_value == seed_of($past(bus.seed_code)));
    endproperty
    a_seed_load: assert property (p_seed_load) // RULE3
        else $error("Seed not loaded on frequency change.");

    property p_seed_hold;
        @(posedge bus.clk) disable iff (!bus.rst_n)
        !(bus.freq_change && bus.load_en) |=>
            ($stable(bus.seed_value) && !bus.seed_load);
    endproperty
    a_seed_hold: assert property (p_seed_hold) // RULE3
        else $error("Seed changed without a qualified change.");

    property p_seed_fix_a;
        @(posedge bus.clk) disable iff (!bus.rst_n)
        (do_load && bus.seed_code == 2'h2) |=>
            bus.seed_value == 24'hB29D08;
    endproperty
    a_seed_fix_a: assert property (p_seed_fix_a) // RULE2
        else $error("Seed code two gave a wrong value.");

    property p_seed_fix_b;
        @(posedge bus.clk) disable iff (!bus.rst_n)
        (do_load && bus.seed_code == 2'h3) |=>
            bus.seed_value == 24'h50F1CD;
    endproperty
    a_seed_fix_b: assert property (p_seed_fix_b) // RULE2
        else $error("Seed code three gave a wrong value.");

    property p_cov_blocked;
        @(posedge bus.clk) disable iff (!bus.rst_n)
        bus.freq_change && !bus.load_en;
    endproperty
    c_cov_blocked: cover property (p_cov_blocked);

endmodule

`default_nettype wire

// ===== rtl/sdcr_top.sv
// Modulator configuration register with seed transfer and core control.
// Assumes a register port from the serial engine on the same clock,
// and strobes for frequency writes and frequency changes on that clock.
`default_nettype none

module sdcr_top
    import sdcr_pkg::*;
(
    input  wire logic              CLK,           // 100 MHz clock.
    input  wire logic              RSTN,          // Asynchronous reset.
    input  wire logic              REG_WE,        // Register write strobe.
    input  wire logic              REG_RE,        // Register read strobe.
    input  wire logic [ADDR_W-1:0] REG_ADDR,      // Register address.
    input  wire logic [DATA_W-1:0] REG_WDATA,     // Write data.
    output logic      [DATA_W-1:0] REG_RDATA,     // Read data, registered.
    input  wire logic              INT_WR,        // Integer freq write.
    input  wire logic              FRAC_WR,       // Fractional freq write.
    input  wire logic              FREQ_CHANGE,   // Frequency change.
    output logic                   AUTOCAL_START, // Autocalibration start.
    output logic                   MOD_BYPASS,    // Modulator output bypass.
    output logic                   CORE_ON,       // Fractional core on.
    output logic                   MOD_CLK_EN,    // Modulator clock enable.
    output logic      [2:0]        INIT_CFG,      // Initialization field.
    output logic                   AUTO_CLK_CFG,  // Auto clock config bit.
    output logic      [SEED_W-1:0] MOD_SEED,      // Seed into modulator.
    output logic                   MOD_SEED_LOAD  // Seed load pulse.
);

    // ****************************************************************
    // Reset release.
    // ****************************************************************
    // Reset is released through two stages so that every flop leaves
    // reset on the same edge; assertion stays asynchronous.
    logic rst_meta_reg;   // First stage, read only by the second.
    logic rst_n;          // Synchronised reset for the whole block.

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ****************************************************************
    // Address decode.
    // ****************************************************************
    // Shared decode for the read and write paths.
    function automatic logic hits_cfg(logic [ADDR_W-1:0] a);
        return a == CFG_OFFSET;
    endfunction

    wire logic wr_hit;   // Write aimed at the configuration register.
    wire logic rd_hit;   // Read aimed at the configuration register.

    assign wr_hit = REG_WE && hits_cfg(REG_ADDR);
    assign rd_hit = REG_RE && hits_cfg(REG_ADDR);

    // ****************************************************************
    // Configuration storage.
    // ****************************************************************
    logic [CFG_W-1:0]  cfg_reg;    // Stored configuration.
    logic [CFG_W-1:0]  cfg_next;   // Next stored configuration.
    logic [DATA_W-1:0] rd_reg;     // Read data register.
    logic [DATA_W-1:0] rd_next;    // Next read data.

    // Writes store every field, seed included; the seed is not
    // applied here but waits for a frequency change.
    assign cfg_next = wr_hit ? REG_WDATA[CFG_W-1:0] : cfg_reg; // RULE3

    // Unmapped reads return zero; bit 23 always reads zero.
    assign rd_next = rd_hit ? {1'b0, cfg_reg} : '0;

    // Register update, reset to the documented default.
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_reg <= CFG_RESET; // RULE1
            rd_reg  <= '0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            rd_reg  <= rd_next;
        end
    end

    assign REG_RDATA = rd_reg;

    // ****************************************************************
    // Field decode and control outputs.
    // ****************************************************************
    wire logic core_on;   // Fractional core enable field.
    wire logic bypass;    // Modulator output bypass field.

    assign core_on = cfg_reg[CORE_ON_BIT];
    assign bypass  = cfg_reg[BYPASS_BIT];

    // The bypass only hides the modulator result; it does not gate the
    // modulator clock, so isolation can be tested in integer mode.
    assign MOD_BYPASS   = bypass;  // RULE4
    assign CORE_ON      = core_on; // RULE7
    assign MOD_CLK_EN   = core_on; // RULE4 RULE7
    assign INIT_CFG     = cfg_reg[INIT_MSB:INIT_LSB];
    assign AUTO_CLK_CFG = cfg_reg[AUTO_CLK_BIT];

    // With the core off the integer write starts calibration, with it
    // on the fractional write does; this is combinational so that the
    // start lines up with the write strobe itself.
    assign AUTOCAL_START = core_on ? FRAC_WR : INT_WR; // RULE6

    // ****************************************************************
    // Seed loader.
    // ****************************************************************
    sdcr_if u_bus (
        .clk   (CLK),
        .rst_n (rst_n)
    );

    // The enable is the stored bit 8, so a write and a change in the
    // same cycle use the value stored before that write.
    assign u_bus.seed_code   = cfg_reg[SEED_MSB:SEED_LSB];
    assign u_bus.load_en     = cfg_reg[LOAD_EN_BIT]; // RULE3
    assign u_bus.freq_change = FREQ_CHANGE;

    sdcr_seed_loader u_loader (
        .bus (u_bus.ldr)
    );

    assign MOD_SEED      = u_bus.seed_value;
    assign MOD_SEED_LOAD = u_bus.seed_load;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    property p_reset_value;
        @(posedge CLK)
        ($rose(rst_n) && !REG_RE) ##1 (REG_RE && !REG_WE &&
            hits_cfg(REG_ADDR) && $past(!REG_WE)) |=>
            REG_RDATA == 24'h200B4A;
    endproperty
    a_reset_value: assert property (p_reset_value) // RULE1
        else $error("Register did not read back its reset value.");

    property p_write_read;
        @(posedge CLK) disable iff (!rst_n)
        wr_hit ##1 (rd_hit && !REG_WE) |=>
            REG_RDATA == {1'b0, $past(REG_WDATA[CFG_W-1:0], 2)};
    endproperty
    a_write_read: assert property (p_write_read) // RULE3
        else $error("Read after write returned other data.");

    property p_unmapped;
        @(posedge CLK) disable iff (!rst_n)
        (REG_RE && !hits_cfg(REG_ADDR)) |=> REG_RDATA == '0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped read returned nonzero data.");

    property p_clk_follows_core;
        @(posedge CLK) disable iff (!rst_n)
        wr_hit |=> (MOD_CLK_EN == $past(REG_WDATA[CORE_ON_BIT]) &&
            MOD_BYPASS == $past(REG_WDATA[BYPASS_BIT]));
    endproperty
    a_clk_follows_core: assert property (p_clk_follows_core) // RULE4
        else $error("Clock enable or bypass did not follow the write.");

    property p_cal_frac;
        @(posedge CLK) disable iff (!rst_n)
        core_on |-> (AUTOCAL_START == FRAC_WR);
    endproperty
    a_cal_frac: assert property (p_cal_frac) // RULE6
        else $error("Calibration start not from fractional write.");

    property p_cal_int;
        @(posedge CLK) disable iff (!rst_n)
        !core_on |-> (AUTOCAL_START == INT_WR && !MOD_CLK_EN);
    endproperty
    a_cal_int: assert property (p_cal_int) // RULE7
        else $error("Core off but calibration or clock misbehaved.");

    // Fields other than bypass and the clock enable follow the write.
    property p_fields_follow;
        @(posedge CLK) disable iff (!rst_n)
        wr_hit |=> (INIT_CFG == $past(REG_WDATA[INIT_MSB:INIT_LSB]) &&
            AUTO_CLK_CFG == $past(REG_WDATA[AUTO_CLK_BIT]) &&
            CORE_ON == $past(REG_WDATA[CORE_ON_BIT]));
    endproperty
    a_fields_follow: assert property (p_fields_follow) // RULE7
        else $error("Stored fields did not follow the write.");

    // Read data stands for one cycle only and then drops to zero.
    property p_rd_idle;
        @(posedge CLK) disable iff (!rst_n)
        !REG_RE |=> REG_RDATA == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("Read data stood without a read.");

    // A read in the same cycle as a write returns the older word.
    property p_rw_same;
        @(posedge CLK) disable iff (!rst_n)
        (rd_hit && wr_hit) |=> REG_RDATA == {1'b0, $past(cfg_reg)};
    endproperty
    a_rw_same: assert property (p_rw_same) // RULE3
        else $error("Read with a write did not return the old word.");

    property p_cov_frac_load;
        @(posedge CLK) disable iff (!rst_n)
        core_on && !bypass && MOD_SEED_LOAD;
    endproperty
    c_cov_frac_load: cover property (p_cov_frac_load);

    property p_cov_int_cal;
        @(posedge CLK) disable iff (!rst_n)
        !core_on && bypass && INT_WR;
    endproperty
    c_cov_int_cal: cover property (p_cov_int_cal);

    property p_cov_wr_then_change;
        @(posedge CLK) disable iff (!rst_n)
        wr_hit ##1 FREQ_CHANGE;
    endproperty
    c_cov_wr_then_change: cover property (p_cov_wr_then_change);

endmodule

`default_nettype wire

// ===== tb/test_sigma_delta_config_register.sv
// Self-checking bench for the modulator configuration register block.
// Assumes sdcr_pkg is compiled first and the bench alone drives all inputs.
`default_nettype none

module test_sigma_delta_config_register
    import sdcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Row of the table: written word and the seed it should load.
    typedef struct {
        logic [23:0] wdata;
        logic [23:0] seed;
    } sdcr_row_s;

    logic              CLK, RSTN, REG_WE, REG_RE;
    logic [5:0]        REG_ADDR;
    logic [23:0]       REG_WDATA, REG_RDATA, MOD_SEED;
    logic              INT_WR, FRAC_WR, FREQ_CHANGE, AUTOCAL_START;
    logic              MOD_BYPASS, CORE_ON, MOD_CLK_EN, AUTO_CLK_CFG;
    logic [2:0]        INIT_CFG;
    logic              MOD_SEED_LOAD;
    int                n_errors   = 0;   // Mismatches seen.
    int                num_checks = 0;   // Comparisons made.
    // Rows cover every seed code; row 1 is the integer-mode setup.
    sdcr_row_s rows [4] = '{'{24'h800B4B, SEED_FIX_B},
                            '{24'h000780, SEED_ZERO},
                            '{24'h200F49, SEED_LSB_VAL},
                            '{24'h400F0A, SEED_FIX_A}};

    sdcr_top uut (.CLK(CLK), .RSTN(RSTN), .REG_WE(REG_WE), .REG_RE(REG_RE),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .INT_WR(INT_WR), .FRAC_WR(FRAC_WR), .FREQ_CHANGE(FREQ_CHANGE),
        .AUTOCAL_START(AUTOCAL_START), .MOD_BYPASS(MOD_BYPASS),
        .CORE_ON(CORE_ON), .MOD_CLK_EN(MOD_CLK_EN), .INIT_CFG(INIT_CFG),
        .AUTO_CLK_CFG(AUTO_CLK_CFG), .MOD_SEED(MOD_SEED),
        .MOD_SEED_LOAD(MOD_SEED_LOAD));

    // ****************************************************************
    // Clock, comparison and drive tasks.
    // ****************************************************************
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({23'h0, got}, {23'h0, exp});
    endtask

    // One request cycle; returns just after the edge that takes it.
    task automatic step(input logic we, input logic re, input logic fc,
                        input logic [5:0] addr, input logic [23:0] wd);
        @(posedge CLK);
        REG_WE      <= we;
        REG_RE      <= re;
        FREQ_CHANGE <= fc;
        REG_ADDR    <= addr;
        REG_WDATA   <= wd;
        @(posedge CLK);
        REG_WE      <= 1'b0;
        REG_RE      <= 1'b0;
        FREQ_CHANGE <= 1'b0;
        #1;
    endtask

    // Write, then read on the very next cycle; returns after the read.
    task automatic wr_rd(input logic [23:0] wd);
        @(posedge CLK);
        REG_WE    <= 1'b1;
        REG_ADDR  <= CFG_OFFSET;
        REG_WDATA <= wd;
        @(posedge CLK);
        REG_WE    <= 1'b0;
        REG_RE    <= 1'b1;
        @(posedge CLK);
        REG_RE    <= 1'b0;
        #1;
    endtask

    // The start strobe is combinational, so it is checked off the edge.
    task automatic autocal(input logic iw, input logic fw, input logic exp);
        @(posedge CLK);
        INT_WR  <= iw;
        FRAC_WR <= fw;
        #1;
        chk_bit(AUTOCAL_START, exp);
    endtask

    // Every level output against the stored word c.
    task automatic check_cfg(input logic [22:0] c);
        chk_bit(MOD_BYPASS, c[7]);
        chk_bit(CORE_ON, c[11]);
        chk_bit(MOD_CLK_EN, c[11]);
        chk_word({21'h0, INIT_CFG}, {21'h0, c[10:8]});
        chk_bit(AUTO_CLK_CFG, c[21]);
        autocal(1'b1, 1'b0, ~c[11]);
        autocal(1'b0, 1'b1, c[11]);
        autocal(1'b0, 1'b0, 1'b0);
    endtask

    // Reset is held nine cycles; the first read is taken four edges later.
    task automatic do_reset();
        @(posedge CLK);
        RSTN <= 1'b0;
        repeat (5) @(posedge CLK);
        #1;
        chk_word(REG_RDATA, 24'h000000);
        chk_word(MOD_SEED, SEED_RESET);
        chk_bit(MOD_SEED_LOAD, 1'b0);
        check_cfg(CFG_RESET);
        @(posedge CLK);
        RSTN <= 1'b1;
        repeat (2) @(posedge CLK);
        step(1'b0, 1'b1, 1'b0, CFG_OFFSET, 24'h0);
        chk_word(REG_RDATA, {1'b0, CFG_RESET});
    endtask

    // Single place where the run ends.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog: the tests need a few hundred cycles at most.
    initial
    begin
        repeat (5000) @(posedge CLK);
        n_errors++;
        stop_test();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        RSTN = 1'b0; REG_WE = 1'b0; REG_RE = 1'b0; REG_ADDR = 6'h00;
        REG_WDATA = 24'h0; INT_WR = 1'b0; FRAC_WR = 1'b0;
        FREQ_CHANGE = 1'b0;
        do_reset();
        $display("test reset done");
        // Bit 23 of row 0 must be dropped on read-back.
        foreach (rows[i])
        begin
            wr_rd(rows[i].wdata);
            chk_word(REG_RDATA, {1'b0, rows[i].wdata[22:0]});
            check_cfg(rows[i].wdata[22:0]);
            step(1'b0, 1'b0, 1'b1, CFG_OFFSET, 24'h0);
            chk_bit(MOD_SEED_LOAD, 1'b1);
            chk_word(MOD_SEED, rows[i].seed);
            @(posedge CLK);
            #1;
            chk_bit(MOD_SEED_LOAD, 1'b0);
            chk_word(REG_RDATA, 24'h0);
        end
        $display("test table done");
        // Load enable clear: a change must leave the seed alone.
        step(1'b1, 1'b0, 1'b0, CFG_OFFSET, 24'h000A4B);
        step(1'b0, 1'b0, 1'b1, CFG_OFFSET, 24'h0);
        chk_bit(MOD_SEED_LOAD, 1'b0);
        chk_word(MOD_SEED, SEED_FIX_A);
        // Write and change together use the old, disabled bit 8.
        step(1'b1, 1'b0, 1'b1, CFG_OFFSET, 24'h000B4B);
        chk_bit(MOD_SEED_LOAD, 1'b0);
        // Back-to-back changes now load the stored code 3 twice.
        @(posedge CLK);
        FREQ_CHANGE <= 1'b1;
        repeat (2) @(posedge CLK);
        FREQ_CHANGE <= 1'b0;
        #1;
        chk_bit(MOD_SEED_LOAD, 1'b1);
        chk_word(MOD_SEED, SEED_FIX_B);
        $display("test seed hold done");
        // Unmapped address: write ignored, read gives zero.
        step(1'b1, 1'b0, 1'b0, 6'h07, 24'hFFFFFF);
        step(1'b0, 1'b1, 1'b0, 6'h07, 24'h0);
        chk_word(REG_RDATA, 24'h000000);
        step(1'b0, 1'b1, 1'b0, CFG_OFFSET, 24'h0);
        chk_word(REG_RDATA, 24'h000B4B);
        // Read and write together: the read sees the older word.
        step(1'b1, 1'b1, 1'b0, CFG_OFFSET, 24'h000A4A);
        chk_word(REG_RDATA, 24'h000B4B);
        step(1'b0, 1'b1, 1'b0, CFG_OFFSET, 24'h0);
        chk_word(REG_RDATA, 24'h000A4A);
        $display("test unmapped done");
        // A second reset in mid-run restores every default.
        do_reset();
        $display("test second reset done");
        stop_test();
    end
endmodule

`default_nettype wire
